//--- src/gpibd_core.sv
// Purpose: Device side of a general purpose instrument bus interface
// Assumes: Wire pins are active low; open-collector pads; the controller owns ATN, IFC and REN
// Notes:   Pin outputs are the pulled-low level; oe_n low means this end pulls the line
// Overview of operation
// - Ignore addressed commands until own listen address has been received.
// - Listen address is hex 20 plus primary address; address 16 gives 36.
// - Bytes received with ATN false are device data, not commands.
// - Full source handshake paces every byte the device sends.
// - Full acceptor handshake with NRFD, NDAC and DAV captures every command byte, and data bytes while addressed to listen.
// - Talk only while addressed to talk, or in talk-only mode; serial poll supported.
// - Own listen address removes the talker-addressed state.
// - Device data accepted only while addressed to listen.
// - Own talk address removes the listener-addressed state.
// - Device can assert service request line.
// - After SPE, talking returns status byte with RQS until SPD.
// - Remote/local state enters remote under REN; full switching with lockout.
// - GTL and SDC honoured only when addressed listener.
// - DCL or addressed SDC clears the received byte and aborts any byte being sent.
// - GET while addressed listener starts a triggered reading.
// - No parallel poll response; data lines never driven for it.
// - Never controller; never drives ATN, IFC or REN.
// - Primary addressing only; secondary addresses are ignored.
// - Bus lines are only pulled low or released.
`timescale 1ns/100ps
module gpibd_core
  import gpibd_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [4:0] pri_addr_i,
  input  wire logic       talk_only_i,
  input  wire logic [7:0] dio_n_i,
  output logic      [7:0] dio_n_o,
  output logic      [7:0] dio_oe_n_o,
  input  wire logic       dav_n_i,
  output logic            dav_n_o,
  output logic            dav_oe_n_o,
  input  wire logic       nrfd_n_i,
  output logic            nrfd_n_o,
  output logic            nrfd_oe_n_o,
  input  wire logic       ndac_n_i,
  output logic            ndac_n_o,
  output logic            ndac_oe_n_o,
  input  wire logic       eoi_n_i,
  output logic            eoi_n_o,
  output logic            eoi_oe_n_o,
  output logic            srq_n_o,
  output logic            srq_oe_n_o,
  input  wire logic       atn_n_i,
  input  wire logic       ifc_n_i,
  input  wire logic       ren_n_i,
  output logic      [7:0] rx_data_o,
  output logic            rx_eoi_o,
  output logic            rx_valid_o,
  input  wire logic       rx_ready_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_eoi_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  input  wire logic [7:0] status_i,
  input  wire logic       rsv_i,
  input  wire logic       goto_local_i,
  output logic            listen_o,
  output logic            talk_o,
  output logic            remote_o,
  output logic            lockout_o,
  output logic            spoll_o,
  output logic            clear_o,
  output logic            trigger_o
);
  typedef enum {A_IDLE, A_RDY, A_ACC, A_HOLD} gpibd_ah_t;

  logic [7:0] dio_s;
  logic       dav_s, eoi_s, atn_s, ifc_s, ren_s, nrfd_s, ndac_s;
  gpibd_sync #(.W(15)) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({~dio_n_i, ~dav_n_i, ~eoi_n_i, ~atn_n_i, ~ifc_n_i, ~ren_n_i, ~nrfd_n_i, ~ndac_n_i}),
    .q_o     ({dio_s, dav_s, eoi_s, atn_s, ifc_s, ren_s, nrfd_s, ndac_s})
  );

  gpibd_ah_t  ah_q, ah_d;
  logic [7:0] byte_q, byte_d;
  logic       beoi_q, beoi_d;
  logic       batn_q, batn_d;
  logic       lad_q, lad_d;
  logic       tad_q, tad_d;
  logic       spm_q, spm_d;
  logic       rem_q, rem_d;
  logic       llo_q, llo_d;
  logic       clr_q, clr_d;
  logic       trg_q, trg_d;
  logic       rxv_q, rxv_d;
  logic [7:0] rxd_q, rxd_d;
  logic       rxe_q, rxe_d;
  logic       sppend_q, sppend_d;

  logic [7:0] my_la, my_ta;
  logic       is_cmd, is_data, do_cmd, do_data;
  logic       sh_req, sh_busy, sh_done, sh_abort, talk_act;
  logic [7:0] sh_data, sh_dio;
  logic       sh_eoi, sh_eoi_o, sh_dav;

  assign my_la = GPIBD_LAG_BASE | {3'h0, pri_addr_i};
  assign my_ta = GPIBD_TAG_BASE | {3'h0, pri_addr_i};

  // Byte completion; command bytes must never stall on the user side
  assign is_cmd  = (ah_q == A_ACC) && batn_q;
  assign is_data = (ah_q == A_ACC) && !batn_q;
  assign do_cmd  = is_cmd;
  assign do_data = is_data && lad_q && !rxv_q;

  // Talker is active only with ATN false
  assign talk_act = (tad_q || talk_only_i) && !atn_s && !ifc_s;
  assign sh_req   = talk_act && !sh_busy && (spm_q ? sppend_q : tx_valid_i);
  assign sh_data  = spm_q ? ((status_i & ~(8'h01 << GPIBD_RQS_POS)) | ({7'h00, rsv_i} << GPIBD_RQS_POS))
                          : tx_data_i;
  assign sh_eoi   = spm_q ? 1'b0 : tx_eoi_i;
  assign sh_abort = !talk_act || clr_q;

  gpibd_src_hs u_src (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .abort_i (sh_abort),
    .req_i   (sh_req),
    .data_i  (sh_data),
    .eoi_i   (sh_eoi),
    .nrfd_i  (nrfd_s),
    .ndac_i  (ndac_s),
    .busy_o  (sh_busy),
    .done_o  (sh_done),
    .dio_o   (sh_dio),
    .eoi_o   (sh_eoi_o),
    .dav_o   (sh_dav)
  );

  always_comb begin
    ah_d     = ah_q;
    byte_d   = byte_q;
    beoi_d   = beoi_q;
    batn_d   = batn_q;
    lad_d    = lad_q;
    tad_d    = tad_q;
    spm_d    = spm_q;
    rem_d    = rem_q;
    llo_d    = llo_q;
    clr_d    = 1'b0;
    trg_d    = 1'b0;
    rxv_d    = rxv_q;
    rxd_d    = rxd_q;
    rxe_d    = rxe_q;
    sppend_d = sppend_q;

    if (rxv_q && rx_ready_i) begin
      rxv_d = 1'b0;
    end

    // Acceptor runs whenever ATN is set, or as addressed listener
    case (ah_q)
      A_IDLE: begin
        if ((atn_s || lad_q) && !dav_s) begin
          ah_d = A_RDY;
        end
      end
      A_RDY: begin
        if (!atn_s && !lad_q) begin
          ah_d = A_IDLE;
        end else if (dav_s) begin
          byte_d = dio_s;
          beoi_d = eoi_s;
          batn_d = atn_s;
          ah_d   = A_ACC;
        end
      end
      A_ACC: begin
        // Data byte waits here for the user side to drain the holding register
        if (do_cmd || do_data || (is_data && !lad_q)) begin
          ah_d = A_HOLD;
        end
      end
      A_HOLD: begin
        if (!dav_s) begin
          ah_d = A_IDLE;
        end
      end
      default: ah_d = A_IDLE;
    endcase

    if (do_data) begin
      rxv_d = 1'b1;
      rxd_d = byte_q;
      rxe_d = beoi_q;
    end

    if (do_cmd) begin
      // Secondary addresses fall through with no effect
      if (byte_q == GPIBD_CMD_UNL) begin
        lad_d = 1'b0;
      end else if (byte_q == GPIBD_CMD_UNT) begin
        tad_d = 1'b0;
      end else if (byte_q == my_la) begin
        lad_d = 1'b1;
        tad_d = 1'b0;
      end else if (byte_q == my_ta) begin
        tad_d = 1'b1;
        lad_d = 1'b0;
      end else if (byte_q[7:GPIBD_GRP_POS] == GPIBD_GRP_MASK[2:0] - 3'h1) begin
        tad_d = 1'b0;
      end else if (byte_q == GPIBD_CMD_SPE) begin
        spm_d    = 1'b1;
        sppend_d = 1'b1;
      end else if (byte_q == GPIBD_CMD_SPD) begin
        spm_d = 1'b0;
      end else if (byte_q == GPIBD_CMD_DCL) begin
        clr_d = 1'b1;
      end else if (byte_q == GPIBD_CMD_LLO) begin
        llo_d = 1'b1;
      end else if (lad_q) begin
        if (byte_q == GPIBD_CMD_SDC) begin
          clr_d = 1'b1;
        end else if (byte_q == GPIBD_CMD_GTL) begin
          rem_d = 1'b0;
        end else if (byte_q == GPIBD_CMD_GET) begin
          trg_d = 1'b1;
        end
      end
    end

    // Status pending clears a cycle after done, so a second status byte is started; a new talk address re-arms it
    if (spm_q && sh_done) begin
      sppend_d = 1'b0;
    end
    if (do_cmd && byte_q == my_ta) begin
      sppend_d = 1'b1;
    end

    if (ren_s && lad_d && !lad_q) begin
      rem_d = 1'b1;
    end
    if (goto_local_i && !llo_q) begin
      rem_d = 1'b0;
    end
    if (!ren_s) begin
      rem_d = 1'b0;
      llo_d = 1'b0;
    end

    if (clr_q) begin
      rxv_d = 1'b0;
    end
    if (ifc_s) begin
      lad_d = 1'b0;
      tad_d = 1'b0;
      spm_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ah_q     <= A_IDLE;
      byte_q   <= 8'h00;
      beoi_q   <= 1'b0;
      batn_q   <= 1'b0;
      lad_q    <= 1'b0;
      tad_q    <= 1'b0;
      spm_q    <= 1'b0;
      rem_q    <= 1'b0;
      llo_q    <= 1'b0;
      clr_q    <= 1'b0;
      trg_q    <= 1'b0;
      rxv_q    <= 1'b0;
      rxd_q    <= 8'h00;
      rxe_q    <= 1'b0;
      sppend_q <= 1'b0;
    end else begin
      ah_q     <= ah_d;
      byte_q   <= byte_d;
      beoi_q   <= beoi_d;
      batn_q   <= batn_d;
      lad_q    <= lad_d;
      tad_q    <= tad_d;
      spm_q    <= spm_d;
      rem_q    <= rem_d;
      llo_q    <= llo_d;
      clr_q    <= clr_d;
      trg_q    <= trg_d;
      rxv_q    <= rxv_d;
      rxd_q    <= rxd_d;
      rxe_q    <= rxe_d;
      sppend_q <= sppend_d;
    end
  end

  // Open-collector drive: only a low level is ever put out
  assign dio_n_o     = 8'h00;
  assign dio_oe_n_o  = ~sh_dio;
  assign dav_n_o     = 1'b0;
  assign dav_oe_n_o  = ~sh_dav;
  assign eoi_n_o     = 1'b0;
  assign eoi_oe_n_o  = ~(sh_eoi_o && sh_dav);
  assign nrfd_n_o    = 1'b0;
  assign nrfd_oe_n_o = !((atn_s || lad_q) && (ah_q != A_RDY));
  assign ndac_n_o    = 1'b0;
  assign ndac_oe_n_o = !((atn_s || lad_q) && (ah_q != A_HOLD));
  assign srq_n_o     = 1'b0;
  assign srq_oe_n_o  = !rsv_i;
  // ATN, IFC and REN are inputs only
  assign tx_ready_o  = talk_act && !spm_q && !sh_busy;
  assign rx_data_o   = rxd_q;
  assign rx_eoi_o    = rxe_q;
  assign rx_valid_o  = rxv_q;
  assign listen_o    = lad_q;
  assign talk_o      = tad_q;
  assign remote_o    = rem_q;
  assign lockout_o   = llo_q;
  assign spoll_o     = spm_q;
  assign clear_o     = clr_q;
  assign trigger_o   = trg_q;
endmodule : gpibd_core

//--- src/gpibd_pkg.sv
// Purpose: Shared constants for the bus device interface
// Assumes: Bus lines are active low on the wire; logic here uses asserted-true levels
// Notes:   Command codes are the standard multiline codes
package gpibd_pkg;
  localparam logic [7:0] GPIBD_CMD_GTL     = 8'h01;
  localparam logic [7:0] GPIBD_CMD_SDC     = 8'h04;
  localparam logic [7:0] GPIBD_CMD_PPC     = 8'h05;
  localparam logic [7:0] GPIBD_CMD_GET     = 8'h08;
  localparam logic [7:0] GPIBD_CMD_LLO     = 8'h11;
  localparam logic [7:0] GPIBD_CMD_DCL     = 8'h14;
  localparam logic [7:0] GPIBD_CMD_PPU     = 8'h15;
  localparam logic [7:0] GPIBD_CMD_SPE     = 8'h18;
  localparam logic [7:0] GPIBD_CMD_SPD     = 8'h19;
  localparam logic [7:0] GPIBD_CMD_UNL     = 8'h3F;
  localparam logic [7:0] GPIBD_CMD_UNT     = 8'h5F;
  localparam logic [7:0] GPIBD_LAG_BASE    = 8'h20;
  localparam logic [7:0] GPIBD_TAG_BASE    = 8'h40;
  localparam logic [7:0] GPIBD_SCG_BASE    = 8'h60;
  localparam logic [2:0] GPIBD_GRP_MASK    = 3'h3;
  localparam int         GPIBD_GRP_POS     = 5;
  localparam int         GPIBD_RQS_POS     = 6;
  localparam logic [4:0] GPIBD_ADDR_RST    = 5'h10;
  localparam int         GPIBD_SETTLE_NS   = 10;
  localparam int         GPIBD_CLK_MHZ     = 200;
  localparam int         GPIBD_SETTLE_CYC  = (GPIBD_SETTLE_NS * GPIBD_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] GPIBD_STB_RST     = 8'h00;
endpackage : gpibd_pkg

//--- src/gpibd_sync.sv
// Purpose: Two-stage synchroniser for a group of bus inputs
// Assumes: Inputs are asynchronous levels
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module gpibd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q;
endmodule : gpibd_sync

//--- src/gpibd_src_hs.sv
// Purpose: Source handshake engine, one byte per request
// Assumes: Ready and accepted inputs already synchronised, asserted-true
// Notes:   Data valid waits a settle time after data is placed
`timescale 1ns/100ps
module gpibd_src_hs
  import gpibd_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       abort_i,
  input  wire logic       req_i,
  input  wire logic [7:0] data_i,
  input  wire logic       eoi_i,
  input  wire logic       nrfd_i,
  input  wire logic       ndac_i,
  output logic            busy_o,
  output logic            done_o,
  output logic [7:0]      dio_o,
  output logic            eoi_o,
  output logic            dav_o
);
  typedef enum {S_IDLE, S_SETTLE, S_WRDY, S_WACC} gpibd_sh_t;
  gpibd_sh_t  st_q, st_d;
  logic [7:0] dat_q, dat_d;
  logic       eoi_q, eoi_d;
  logic       dav_q, dav_d;
  logic       done_q, done_d;
  logic [3:0] cnt_q, cnt_d;

  always_comb begin
    st_d   = st_q;
    dat_d  = dat_q;
    eoi_d  = eoi_q;
    dav_d  = dav_q;
    cnt_d  = cnt_q;
    done_d = 1'b0;
    case (st_q)
      S_IDLE: begin
        dav_d = 1'b0;
        if (req_i) begin
          dat_d = data_i;
          eoi_d = eoi_i;
          cnt_d = 4'(GPIBD_SETTLE_CYC);
          st_d  = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          st_d = S_WRDY;
        end
      end
      S_WRDY: begin
        // Wait for every acceptor ready and none accepted yet
        if (!nrfd_i && ndac_i) begin
          dav_d = 1'b1;
          st_d  = S_WACC;
        end
      end
      S_WACC: begin
        if (!ndac_i) begin
          dav_d  = 1'b0;
          done_d = 1'b1;
          st_d   = S_IDLE;
        end
      end
      default: st_d = S_IDLE;
    endcase
    if (abort_i) begin
      st_d  = S_IDLE;
      dav_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_q   <= S_IDLE;
      dat_q  <= 8'h00;
      eoi_q  <= 1'b0;
      dav_q  <= 1'b0;
      done_q <= 1'b0;
      cnt_q  <= 4'h0;
    end else begin
      st_q   <= st_d;
      dat_q  <= dat_d;
      eoi_q  <= eoi_d;
      dav_q  <= dav_d;
      done_q <= done_d;
      cnt_q  <= cnt_d;
    end
  end

  assign busy_o = (st_q != S_IDLE);
  assign done_o = done_q;
  assign dio_o  = (st_q == S_IDLE) ? 8'h00 : dat_q;
  assign eoi_o  = (st_q == S_IDLE) ? 1'b0 : eoi_q;
  assign dav_o  = dav_q;
endmodule : gpibd_src_hs

//--- verification/gpibd_chk.sv
// Purpose: Concurrent checks on the device core ports
// Assumes: Wire inputs are active low; sync latency is at least two cycles
// Notes:   Margins on past samples allow for the input synchroniser
`timescale 1ns/100ps
module gpibd_chk (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       talk_only_i,
  input  wire logic [7:0] dio_oe_n_o,
  input  wire logic       dav_oe_n_o,
  input  wire logic       nrfd_n_i,
  input  wire logic       ndac_n_i,
  input  wire logic       atn_n_i,
  input  wire logic       rsv_i,
  input  wire logic       srq_oe_n_o,
  input  wire logic       listen_o,
  input  wire logic       talk_o,
  input  wire logic       clear_o,
  input  wire logic       trigger_o,
  input  wire logic       rx_valid_o,
  input  wire logic       rx_ready_i,
  input  wire logic [7:0] rx_data_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_ready_seen;
    $past(nrfd_n_i, 3) && !$past(ndac_n_i, 3);
  endsequence
  sequence s_accepted;
    $past(ndac_n_i, 3) || !$past(atn_n_i, 3);
  endsequence

  a_dav_on_ready: assert property ($fell(dav_oe_n_o) |-> s_ready_seen)
    else $error("DAV asserted before ready");
  a_dav_off_accepted: assert property ($rose(dav_oe_n_o) |-> s_accepted)
    else $error("DAV dropped before accepted");
  a_data_stable: assert property (!dav_oe_n_o && !$past(dav_oe_n_o) |-> $stable(dio_oe_n_o))
    else $error("data moved under DAV");
  a_dio_talker: assert property (dio_oe_n_o != 8'hFF |-> talk_o || talk_only_i || $past(talk_o, 2))
    else $error("data lines driven while not talker");
  a_rx_hold: assert property (rx_valid_o && !rx_ready_i && !clear_o |=> rx_valid_o && $stable(rx_data_o))
    else $error("received byte lost");
  a_rx_listen: assert property ($rose(rx_valid_o) |-> listen_o)
    else $error("data taken while not listener");
  a_addr_excl: assert property (!(listen_o && talk_o))
    else $error("listener and talker together");
  a_clear_cmd: assert property (clear_o |-> !$past(atn_n_i, 2))
    else $error("clear without command");
  a_trig_listen: assert property (trigger_o |-> listen_o && !$past(atn_n_i, 2))
    else $error("trigger while not listener");
  a_srq_rsv: assert property ($rose(rsv_i) |-> ##[0:4] !srq_oe_n_o)
    else $error("service request not raised");
endmodule : gpibd_chk

bind gpibd_core gpibd_chk u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .talk_only_i(talk_only_i), .dio_oe_n_o(dio_oe_n_o),
  .dav_oe_n_o(dav_oe_n_o), .nrfd_n_i(nrfd_n_i), .ndac_n_i(ndac_n_i), .atn_n_i(atn_n_i),
  .rsv_i(rsv_i), .srq_oe_n_o(srq_oe_n_o), .listen_o(listen_o), .talk_o(talk_o), .clear_o(clear_o),
  .trigger_o(trigger_o), .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o)
);

//--- verification/gpibd_ctl_model.sv
// Purpose: Behavioural bus controller facing the device core
// Assumes: Outputs are asserted-true pulls; released lines float high
// Notes:   Every wait is bounded; ok reports a completed handshake
`timescale 1ns/100ps
module gpibd_ctl_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] dio_n_i,
  input  wire logic       dav_n_i,
  input  wire logic       nrfd_n_i,
  input  wire logic       ndac_n_i,
  output logic      [7:0] dio_o,
  output logic            dav_o,
  output logic            nrfd_o,
  output logic            ndac_o,
  output logic            atn_o,
  output logic            ren_o,
  output logic            ifc_o
);
  initial begin
    dio_o = 8'h00;
    dav_o = 1'h0;
    nrfd_o = 1'h0;
    ndac_o = 1'h0;
    atn_o = 1'h0;
    ren_o = 1'h0;
    ifc_o = 1'h0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc

  // Give the device time to see ATN move before the next byte
  task automatic set_atn(input logic v);
    if (atn_o !== v) begin
      atn_o = v;
      cyc(6);
    end
  endtask : set_atn

  task automatic set_ren(input logic v);
    ren_o = v;
    cyc(4);
  endtask : set_ren

  task automatic set_ifc(input logic v);
    ifc_o = v;
    cyc(4);
  endtask : set_ifc

  task automatic put(input logic atn, input logic [7:0] b, output logic ok);
    int n;
    n = 0;
    nrfd_o = 1'h0;
    ndac_o = 1'h0;
    set_atn(atn);
    while (n < 300 && nrfd_n_i !== 1'h1) begin
      cyc(1);
      n++;
    end
    dio_o = b;
    cyc(2);
    dav_o = 1'h1;
    while (n < 300 && ndac_n_i !== 1'h1) begin
      cyc(1);
      n++;
    end
    ok = (n < 300);
    dav_o = 1'h0;
    dio_o = 8'h00;
    cyc(4);
  endtask : put

  task automatic get(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    set_atn(1'h0);
    ndac_o = 1'h1;
    nrfd_o = 1'h0;
    while (n < 300 && dav_n_i !== 1'h0) begin
      cyc(1);
      n++;
    end
    b = ~dio_n_i;
    nrfd_o = 1'h1;
    ndac_o = 1'h0;
    while (n < 300 && dav_n_i !== 1'h1) begin
      cyc(1);
      n++;
    end
    ndac_o = 1'h1;
    ok = (n < 300);
    cyc(2);
  endtask : get
endmodule : gpibd_ctl_model

//--- verification/tb_ieee488_device_interface.sv
// Purpose: Self-checking bench for the device core
// Assumes: Primary address 16; open-drain wires resolved here
// Notes:   Addressing cases run from a table; the rest are hand-written
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_ieee488_device_interface
  import gpibd_pkg::*;
;
  logic       clk, rst_n, rx_ready, tx_valid, rsv, gtl, k;
  logic       m_eoi, tonly, teoi, eoi_dav, rx_eoi;
  logic       dav_oe, nrfd_oe, ndac_oe, eoi_oe, srq_oe, rx_valid, tx_ready;
  logic       listen, talk, remote, lockout, spoll, clr, trg;
  logic       m_dav, m_nrfd, m_ndac, m_atn, m_ren, m_ifc;
  logic [7:0] dio_oe, rx_data, tx_data, m_dio, b;
  logic [7:0] rxq[$];
  int         fail_count, n_compared, n_clr, n_trg;
  logic [9:0] rows[11] = '{{8'h3F, 2'h0}, {8'h36, 2'h2}, {8'h56, 2'h1}, {8'h36, 2'h2}, {8'h37, 2'h2},
    {8'h3F, 2'h0}, {8'h56, 2'h1}, {8'h5F, 2'h0}, {8'h56, 2'h1}, {8'h41, 2'h0}, {8'h70, 2'h0}};
  wire  [7:0] dio_w = ~(m_dio | ~dio_oe);
  wire        dav_w = ~(m_dav | ~dav_oe);
  wire        nrfd_w = ~(m_nrfd | ~nrfd_oe);
  wire        ndac_w = ~(m_ndac | ~ndac_oe);
  wire        eoi_w = ~(m_eoi | ~eoi_oe);

  gpibd_core dut (
    .clk_i(clk), .rst_n_i(rst_n), .pri_addr_i(5'h16), .talk_only_i(tonly),
    .dio_n_i(dio_w), .dio_n_o(), .dio_oe_n_o(dio_oe), .dav_n_i(dav_w), .dav_n_o(), .dav_oe_n_o(dav_oe),
    .nrfd_n_i(nrfd_w), .nrfd_n_o(), .nrfd_oe_n_o(nrfd_oe), .ndac_n_i(ndac_w), .ndac_n_o(),
    .ndac_oe_n_o(ndac_oe), .eoi_n_i(eoi_w), .eoi_n_o(), .eoi_oe_n_o(eoi_oe), .srq_n_o(),
    .srq_oe_n_o(srq_oe), .atn_n_i(~m_atn), .ifc_n_i(~m_ifc), .ren_n_i(~m_ren),
    .rx_data_o(rx_data), .rx_eoi_o(rx_eoi), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
    .tx_data_i(tx_data), .tx_eoi_i(teoi), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
    .status_i(8'h05), .rsv_i(rsv), .goto_local_i(gtl), .listen_o(listen), .talk_o(talk),
    .remote_o(remote), .lockout_o(lockout), .spoll_o(spoll), .clear_o(clr), .trigger_o(trg)
  );

  gpibd_ctl_model m (
    .clk_i(clk), .dio_n_i(dio_w), .dav_n_i(dav_w), .nrfd_n_i(nrfd_w), .ndac_n_i(ndac_w),
    .dio_o(m_dio), .dav_o(m_dav), .nrfd_o(m_nrfd), .ndac_o(m_ndac), .atn_o(m_atn),
    .ren_o(m_ren), .ifc_o(m_ifc)
  );

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (rx_valid && rx_ready) begin
      rxq.push_back(rx_data);
    end
    n_clr <= n_clr + int'(clr);
    n_trg <= n_trg + int'(trg);
    if (dav_w === 1'h0) begin
      eoi_dav <= ~eoi_w;
    end
  end

  task automatic stop_test();
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic cmd(input logic [7:0] c, input logic atn = 1'h1);
    logic ok;
    m.put(atn, c, ok);
    `CHK("handshake", 1'h1, ok)
  endtask : cmd

  // Offer one byte and hold it until the core takes it
  // Ready is read once settled, so the edge that takes the byte is known before it comes
  task automatic tx(input logic [7:0] d);
    int   n;
    logic rdy;
    n = 0;
    tx_data = d;
    tx_valid = 1'h1;
    #1 rdy = tx_ready;
    while (rdy !== 1'h1 && n < 300) begin
      @(posedge clk);
      #2 rdy = tx_ready;
      n++;
    end
    @(posedge clk);
    #1 tx_valid = 1'h0;
    `CHK("tx taken", 1'h1, n < 300)
  endtask : tx

  initial begin
    clk = 1'h0;
    rst_n = 1'h0;
    rx_ready = 1'h1;
    tx_valid = 1'h0;
    tx_data = 8'h00;
    rsv = 1'h0;
    gtl = 1'h0;
    m_eoi = 1'h0;
    tonly = 1'h0;
    teoi = 1'h0;
    fail_count = 0;
    n_compared = 0;
    n_clr = 0;
    n_trg = 0;
    repeat (9) @(posedge clk);
    #1;
    `CHK("reset", 16'hFFF8, {dio_oe, dav_oe, nrfd_oe, ndac_oe, eoi_oe, srq_oe, listen, talk, remote})
    @(posedge clk);
    #1 rst_n = 1'h1;
    repeat (4) @(posedge clk);
    foreach (rows[i]) begin
      cmd(rows[i][9:2]);
      `CHK("listen", rows[i][1], listen)
      `CHK("talk", rows[i][0], talk)
    end
    cmd(GPIBD_CMD_UNL);
    cmd(GPIBD_CMD_SDC);
    `CHK("sdc unaddressed", 0, n_clr)
    cmd(8'h36);
    cmd(GPIBD_CMD_SDC);
    `CHK("sdc", 1, n_clr)
    cmd(GPIBD_CMD_UNL);
    cmd(GPIBD_CMD_DCL);
    `CHK("dcl", 2, n_clr)
    cmd(GPIBD_CMD_GET);
    `CHK("get unaddressed", 0, n_trg)
    cmd(8'h36);
    cmd(GPIBD_CMD_PPC);
    `CHK("no ppoll", 8'hFF, dio_oe)
    cmd(GPIBD_CMD_GET);
    `CHK("get", 1, n_trg)
    rx_ready = 1'h0;
    fork
      cmd(8'h2A, 1'h0);
      begin
        repeat (40) @(posedge clk);
        #1 rx_ready = 1'h1;
      end
    join
    m_eoi = 1'h1;
    cmd(8'h52, 1'h0);
    m_eoi = 1'h0;
    `CHK("rx eoi", 1'h1, rx_eoi)
    `CHK("rx count", 2, rxq.size())
    `CHK("rx first", 8'h2A, rxq[0])
    `CHK("rx second", 8'h52, rxq[1])
    cmd(GPIBD_CMD_UNL);
    cmd(8'h53, 1'h0);
    `CHK("rx unlistened", 2, rxq.size())
    tonly = 1'h1;
    fork
      tx(8'h3C);
      m.get(b, k);
    join
    tonly = 1'h0;
    `CHK("talk only", 8'h3C, b)
    cmd(8'h56);
    teoi = 1'h1;
    fork
      tx(8'hA5);
      m.get(b, k);
    join
    teoi = 1'h0;
    `CHK("talk byte", 8'hA5, b)
    `CHK("get ok", 1'h1, k)
    `CHK("talk eoi", 1'h1, eoi_dav)
    rsv = 1'h1;
    repeat (8) @(posedge clk);
    `CHK("srq", 1'h0, srq_oe)
    cmd(GPIBD_CMD_SPE);
    cmd(8'h56);
    m.get(b, k);
    `CHK("status", 8'h45, b)
    `CHK("status eoi", 1'h0, eoi_dav)
    `CHK("spoll on", 1'h1, spoll)
    cmd(GPIBD_CMD_SPD);
    `CHK("spoll off", 1'h0, spoll)
    rsv = 1'h0;
    m.set_ren(1'h1);
    cmd(GPIBD_CMD_UNL);
    cmd(8'h36);
    `CHK("remote", 1'h1, remote)
    cmd(GPIBD_CMD_GTL);
    `CHK("gtl", 1'h0, remote)
    cmd(GPIBD_CMD_UNL);
    cmd(8'h36);
    cmd(GPIBD_CMD_UNL);
    cmd(GPIBD_CMD_GTL);
    `CHK("gtl unaddressed", 1'h1, remote)
    cmd(GPIBD_CMD_LLO);
    `CHK("lockout", 1'h1, lockout)
    gtl = 1'h1;
    repeat (4) @(posedge clk);
    `CHK("local key locked", 1'h1, remote)
    #1 gtl = 1'h0;
    m.set_ren(1'h0);
    repeat (6) @(posedge clk);
    `CHK("ren off", 1'h0, remote)
    m.set_ren(1'h1);
    cmd(GPIBD_CMD_UNL);
    cmd(8'h36);
    `CHK("remote again", 1'h1, remote)
    gtl = 1'h1;
    repeat (4) @(posedge clk);
    #1 gtl = 1'h0;
    `CHK("local key", 1'h0, remote)
    m.set_ifc(1'h1);
    `CHK("ifc", 2'h0, {listen, talk})
    m.set_ifc(1'h0);
    stop_test();
  end
endmodule : tb_ieee488_device_interface
